// [core/dcp_pkg.sv]
// Package with register map, field layouts and reset values of the clock and power configuration bank
package dcp_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] RING_OSC_CTRL_ADDR  = 12'h083;
    localparam logic [ADDR_W-1:0] SYNC_REF_CTRL_ADDR  = 12'h084;
    localparam logic [ADDR_W-1:0] STARTUP_SEQ_ADDR    = 12'h085;
    localparam logic [ADDR_W-1:0] CLK_SWING_ADDR      = 12'h08D;
    localparam logic [ADDR_W-1:0] CLK_OUT_POWER_ADDR  = 12'h08F;
    localparam logic [ADDR_W-1:0] CONV_POWER_ADDR     = 12'h090;

    // Writable bit masks per register
    localparam logic [DATA_W-1:0] RING_OSC_WMASK   = 8'h83;
    localparam logic [DATA_W-1:0] SYNC_REF_WMASK   = 8'hFF;
    localparam logic [DATA_W-1:0] STARTUP_WMASK    = 8'h73;
    localparam logic [DATA_W-1:0] CLK_SWING_WMASK  = 8'h1F;
    localparam logic [DATA_W-1:0] CLK_POWER_WMASK  = 8'h01;
    localparam logic [DATA_W-1:0] CONV_POWER_WMASK = 8'h03;

    // Reset values
    localparam logic [DATA_W-1:0] RING_OSC_RST   = 8'h00;
    localparam logic [DATA_W-1:0] SYNC_REF_RST   = 8'h00;
    localparam logic [DATA_W-1:0] STARTUP_RST    = 8'h13;
    localparam logic [DATA_W-1:0] CLK_SWING_RST  = 8'h00;
    localparam logic [DATA_W-1:0] CLK_POWER_RST  = 8'h00;
    localparam logic [DATA_W-1:0] CONV_POWER_RST = 8'h03;

    // Field positions
    localparam int RING_DIV_LSB      = 0;
    localparam int SYNC_COUPLING_BIT = 6;
    localparam int SYNC_OFF_BIT      = 0;
    localparam int SEQ_A_LSB         = 4;
    localparam int SEQ_B_BIT         = 1;
    localparam int SEQ_C_BIT         = 0;
    localparam int SWING_LSB         = 0;
    localparam int DRIVER_OFF_BIT    = 0;
    localparam int CONV1_OFF_BIT     = 1;
    localparam int CONV0_OFF_BIT     = 0;

    localparam logic [4:0] SWING_MAX_CODE = 5'h13;

    typedef enum logic [1:0] {
        DCP_DIV8,
        DCP_DIV16,
        DCP_DIV32,
        DCP_DIV64
    } dcp_ring_div_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } dcp_bus_req_s;

    typedef struct packed {
        dcp_ring_div_e ring_osc_divide_select;
        logic          sync_ref_coupling_select;
        logic          sync_ref_receiver_off;
        logic [2:0]    startup_seq_ctrl_a;
        logic          startup_seq_ctrl_b;
        logic          startup_seq_ctrl_c;
        logic [4:0]    obs_clock_swing_code;
        logic          obs_clock_driver_off;
        logic          converter1_power_off;
        logic          converter0_power_off;
    } dcp_ctrl_s;

    typedef struct packed {
        logic [DATA_W-1:0] ring_osc_ff;
        logic [DATA_W-1:0] sync_ref_ff;
        logic [DATA_W-1:0] startup_ff;
        logic [DATA_W-1:0] swing_ff;
        logic [DATA_W-1:0] clk_power_ff;
        logic [DATA_W-1:0] conv_power_ff;
        logic [DATA_W-1:0] rdata_ff;
        logic              rvalid_ff;
        dcp_ctrl_s         ctrl_ff;
    } dcp_state_s;
endpackage

// [core/dcp_regs.sv]
// Clock and power configuration register bank with plain read and write port
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module dcp_regs
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire dcp_pkg::dcp_bus_req_s     bus_req,
    output logic [dcp_pkg::DATA_W-1:0]     bus_rdata,
    output logic                           bus_rvalid,
    output dcp_pkg::dcp_ctrl_s             ctrl
);
    import dcp_pkg::*;

    dcp_state_s st_ff;
    dcp_state_s nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic [DATA_W-1:0] rv;
        logic [4:0]        sw;
        rv     = '0;
        sw     = '0;
        nxt_st = st_ff;
        nxt_st.rvalid_ff = bus_req.rd;
        if (bus_req.wr)
        begin
            unique case (bus_req.addr)
                RING_OSC_CTRL_ADDR:
                    nxt_st.ring_osc_ff = bus_req.wdata & RING_OSC_WMASK;
                SYNC_REF_CTRL_ADDR:
                    nxt_st.sync_ref_ff = bus_req.wdata & SYNC_REF_WMASK;
                STARTUP_SEQ_ADDR:
                    nxt_st.startup_ff = bus_req.wdata & STARTUP_WMASK;
                CLK_SWING_ADDR:
                    nxt_st.swing_ff = bus_req.wdata & CLK_SWING_WMASK;
                CLK_OUT_POWER_ADDR:
                    nxt_st.clk_power_ff = bus_req.wdata & CLK_POWER_WMASK;
                CONV_POWER_ADDR:
                    nxt_st.conv_power_ff = bus_req.wdata & CONV_POWER_WMASK;
                default:
                    nxt_st.rdata_ff = st_ff.rdata_ff;
            endcase
        end
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                RING_OSC_CTRL_ADDR: rv = st_ff.ring_osc_ff;
                SYNC_REF_CTRL_ADDR: rv = st_ff.sync_ref_ff;
                STARTUP_SEQ_ADDR:   rv = st_ff.startup_ff;
                CLK_SWING_ADDR:     rv = st_ff.swing_ff;
                CLK_OUT_POWER_ADDR: rv = st_ff.clk_power_ff;
                CONV_POWER_ADDR:    rv = st_ff.conv_power_ff;
                default:            rv = '0;
            endcase
        end
        nxt_st.rdata_ff = rv;

        // Control decode from the next register image
        nxt_st.ctrl_ff.ring_osc_divide_select =
            dcp_ring_div_e'(nxt_st.ring_osc_ff[RING_DIV_LSB +: 2]);
        nxt_st.ctrl_ff.sync_ref_coupling_select = nxt_st.sync_ref_ff[SYNC_COUPLING_BIT];
        nxt_st.ctrl_ff.sync_ref_receiver_off = nxt_st.sync_ref_ff[SYNC_OFF_BIT];
        nxt_st.ctrl_ff.startup_seq_ctrl_a = nxt_st.startup_ff[SEQ_A_LSB +: 3];
        nxt_st.ctrl_ff.startup_seq_ctrl_b = nxt_st.startup_ff[SEQ_B_BIT];
        nxt_st.ctrl_ff.startup_seq_ctrl_c = nxt_st.startup_ff[SEQ_C_BIT];
        sw = nxt_st.swing_ff[SWING_LSB +: 5];
        // Codes above the defined range are stored but drive the last defined code
        nxt_st.ctrl_ff.obs_clock_swing_code = (sw > SWING_MAX_CODE) ? SWING_MAX_CODE : sw;
        nxt_st.ctrl_ff.obs_clock_driver_off = nxt_st.clk_power_ff[DRIVER_OFF_BIT];
        nxt_st.ctrl_ff.converter1_power_off = nxt_st.conv_power_ff[CONV1_OFF_BIT];
        nxt_st.ctrl_ff.converter0_power_off = nxt_st.conv_power_ff[CONV0_OFF_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff.ring_osc_ff   <= RING_OSC_RST;
            st_ff.sync_ref_ff   <= SYNC_REF_RST;
            st_ff.startup_ff    <= STARTUP_RST;
            st_ff.swing_ff      <= CLK_SWING_RST;
            st_ff.clk_power_ff  <= CLK_POWER_RST;
            st_ff.conv_power_ff <= CONV_POWER_RST;
            st_ff.rdata_ff      <= '0;
            st_ff.rvalid_ff     <= 1'b0;
            st_ff.ctrl_ff.ring_osc_divide_select   <= dcp_ring_div_e'(RING_OSC_RST[RING_DIV_LSB +: 2]);
            st_ff.ctrl_ff.sync_ref_coupling_select <= SYNC_REF_RST[SYNC_COUPLING_BIT];
            st_ff.ctrl_ff.sync_ref_receiver_off    <= SYNC_REF_RST[SYNC_OFF_BIT];
            st_ff.ctrl_ff.startup_seq_ctrl_a       <= STARTUP_RST[SEQ_A_LSB +: 3];
            st_ff.ctrl_ff.startup_seq_ctrl_b       <= STARTUP_RST[SEQ_B_BIT];
            st_ff.ctrl_ff.startup_seq_ctrl_c       <= STARTUP_RST[SEQ_C_BIT];
            st_ff.ctrl_ff.obs_clock_swing_code     <= CLK_SWING_RST[SWING_LSB +: 5];
            st_ff.ctrl_ff.obs_clock_driver_off     <= CLK_POWER_RST[DRIVER_OFF_BIT];
            st_ff.ctrl_ff.converter1_power_off     <= CONV_POWER_RST[CONV1_OFF_BIT];
            st_ff.ctrl_ff.converter0_power_off     <= CONV_POWER_RST[CONV0_OFF_BIT];
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign bus_rdata  = st_ff.rdata_ff;
    assign bus_rvalid = st_ff.rvalid_ff;
    assign ctrl       = st_ff.ctrl_ff;
endmodule

// [tb/dcp_regs_assertions.sv]
// Concurrent checks for the clock and power bank
`timescale 1ns/100ps
module dcp_regs_assertions
(
    input wire logic                       core_clk,
    input wire logic                       rst_b,
    input wire dcp_pkg::dcp_bus_req_s      bus_req,
    input wire logic [dcp_pkg::DATA_W-1:0] bus_rdata,
    input wire logic                       bus_rvalid,
    input wire dcp_pkg::dcp_ctrl_s         ctrl
);
    import dcp_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence wr_at(logic [11:0] a);
        bus_req.wr && bus_req.addr == a;
    endsequence
    a_ring_div: assert property (wr_at(RING_OSC_CTRL_ADDR) |=> ctrl.ring_osc_divide_select == $past(bus_req.wdata[1:0]))
        else $error("divider mismatch");
    a_sync_coupling: assert property (wr_at(SYNC_REF_CTRL_ADDR) |=> ctrl.sync_ref_coupling_select == $past(bus_req.wdata[6]))
        else $error("coupling mismatch");
    a_sync_rx_off: assert property (wr_at(SYNC_REF_CTRL_ADDR) |=> ctrl.sync_ref_receiver_off == $past(bus_req.wdata[0]))
        else $error("receiver off mismatch");
    a_swing_code: assert property (wr_at(CLK_SWING_ADDR) |=> ctrl.obs_clock_swing_code == (($past(bus_req.wdata[4:0]) > 5'h13) ? 5'h13 : $past(bus_req.wdata[4:0])))
        else $error("swing mismatch");
    a_driver_off: assert property (wr_at(CLK_OUT_POWER_ADDR) |=> ctrl.obs_clock_driver_off == $past(bus_req.wdata[0]))
        else $error("driver off mismatch");
    a_conv1_off: assert property (wr_at(CONV_POWER_ADDR) |=> ctrl.converter1_power_off == $past(bus_req.wdata[1]))
        else $error("converter 1 mismatch");
    a_conv0_off: assert property (wr_at(CONV_POWER_ADDR) |=> ctrl.converter0_power_off == $past(bus_req.wdata[0]))
        else $error("converter 0 mismatch");
    a_ro_zero: assert property (bus_rvalid && $past(bus_req.addr) == CLK_OUT_POWER_ADDR |-> bus_rdata[7:1] == 7'h00)
        else $error("read-only bits not zero");
    a_startup_hold: assert property (!bus_req.wr |=> $stable(ctrl.startup_seq_ctrl_a) && $stable(ctrl.startup_seq_ctrl_c))
        else $error("startup bits moved");
endmodule
bind dcp_regs dcp_regs_assertions u_chk (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ctrl(ctrl));

// [tb/dcp_regs_bench.sv]
// Self-checking bench for the clock and power bank
`timescale 1ns/100ps
module dcp_regs_bench;
    import dcp_pkg::*;
    logic              core_clk;
    logic              rst_b = 1'b0;
    dcp_bus_req_s      bus_req = '0;
    logic [DATA_W-1:0] bus_rdata;
    logic              bus_rvalid;
    dcp_ctrl_s         ctrl;
    int                error_cnt = 0;
    int                tests_run = 0;
    // Address, write data, expected read back
    logic [27:0]       rows [8] = '{28'h084FFFF, 28'h085FF73, 28'h08D1313, 28'h08D1F1F,
                                    28'h08FFF01, 28'h0900000, 28'h083FF83, 28'h0A05500};
    logic [19:0]       rst_rows [6] = '{20'h08300, 20'h08400, 20'h08513, 20'h08D00, 20'h08F00, 20'h09003};
    dcp_regs dut (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .ctrl(ctrl));
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk({7'h00, bus_rvalid}, 8'h01);
        chk(bus_rdata, e);
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        error_cnt++;
        stop_test();
    end
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        wr_reg(STARTUP_SEQ_ADDR, 8'h12);
        #1;
        chk({3'h0, ctrl.startup_seq_ctrl_a, ctrl.startup_seq_ctrl_b, ctrl.startup_seq_ctrl_c}, 8'h06);
        foreach (rows[i])
        begin
            wr_reg(rows[i][27:16], rows[i][15:8]);
            rd_reg(rows[i][27:16], rows[i][7:0]);
        end
        chk({3'h0, ctrl.obs_clock_swing_code}, 8'h13);
        chk({7'h00, ctrl.obs_clock_driver_off}, 8'h01);
        @(posedge core_clk);
        bus_req <= '{addr: CONV_POWER_ADDR, wdata: 8'h02, wr: 1'b1, rd: 1'b0};
        rd_reg(CONV_POWER_ADDR, 8'h02);
        chk({6'h00, ctrl.converter1_power_off, ctrl.converter0_power_off}, 8'h02);
        wr_reg(CLK_SWING_ADDR, 8'h09);
        #1;
        chk({3'h0, ctrl.obs_clock_swing_code}, 8'h09);
        wr_reg(RING_OSC_CTRL_ADDR, 8'h02);
        #1;
        chk({6'h00, ctrl.ring_osc_divide_select}, 8'h02);
        wr_reg(SYNC_REF_CTRL_ADDR, 8'h01);
        #1;
        chk({6'h00, ctrl.sync_ref_coupling_select, ctrl.sync_ref_receiver_off}, 8'h01);
        wr_reg(STARTUP_SEQ_ADDR, 8'h01);
        #1;
        chk({3'h0, ctrl.startup_seq_ctrl_a, ctrl.startup_seq_ctrl_b, ctrl.startup_seq_ctrl_c}, 8'h01);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (rst_rows[i])
            rd_reg(rst_rows[i][19:8], rst_rows[i][7:0]);
        chk({6'h00, ctrl.converter1_power_off, ctrl.converter0_power_off}, 8'h03);
        chk({3'h0, ctrl.startup_seq_ctrl_a, ctrl.startup_seq_ctrl_b, ctrl.startup_seq_ctrl_c}, 8'h07);
        chk({6'h00, ctrl.ring_osc_divide_select}, 8'h00);
        chk({6'h00, ctrl.sync_ref_coupling_select, ctrl.sync_ref_receiver_off}, 8'h00);
        stop_test();
    end
endmodule
